// >>> verification/bcseq_asserts.sv
`timescale 1ns/1ps
module bcseq_asserts #(
   parameter int PULSE_CYC = 8
)(
   input wire logic       clock_i,
   input wire logic       nrst_i,
   input wire logic       in_uv_ok_i,
   input wire logic       in_ov_6v_i,
   input wire logic       in_ov_11v_i,
   input wire logic       batt_above_pre_i,
   input wire logic       batt_over_104_i,
   input wire logic [2:0] thermistor_zone_i,
   input wire logic       die_hot_i,
   input wire logic       switch_en_o,
   input wire logic       precharge_sel_o,
   input wire logic       derate_i_en_o,
   input wire logic       derate_v_en_o,
   input wire logic       batt_sink_en_o,
   input wire logic       int_oe_n_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);

   // low cycles of the current interrupt pulse
   int lo_cnt;
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         lo_cnt <= 0;
      else if (int_oe_n_o)
         lo_cnt <= 0;
      else
         lo_cnt <= lo_cnt + 1;
   end

   a_int_width: assert property ($rose(int_oe_n_o) && lo_cnt != 0 |-> lo_cnt == PULSE_CYC)
      else $error("interrupt pulse width wrong");
   a_int_bound: assert property (lo_cnt <= PULSE_CYC)
      else $error("interrupt pulse too long");
   a_int_gap: assert property (!int_oe_n_o && lo_cnt == PULSE_CYC - 1 |=> int_oe_n_o)
      else $error("interrupt pulses overlap");
   a_uv_off: assert property ((!in_uv_ok_i)[*6] |-> !switch_en_o)
      else $error("switching with input undervoltage");
   a_ovp_off: assert property ((in_ov_6v_i && in_ov_11v_i)[*6] |-> !switch_en_o)
      else $error("switching with input overvoltage");
   a_hot_off: assert property (die_hot_i[*6] |-> !switch_en_o)
      else $error("switching in thermal shutdown");
   a_pre_sel: assert property ((!batt_above_pre_i)[*6] |-> precharge_sel_o)
      else $error("low battery without precharge current");
   a_sink_off: assert property ((!batt_over_104_i)[*6] |-> !batt_sink_en_o)
      else $error("discharge sink on at normal voltage");
   a_derate_i: assert property ((thermistor_zone_i != 3'h2)[*6] |-> !derate_i_en_o)
      else $error("current derated outside cool zone");
   a_derate_v: assert property ((thermistor_zone_i != 3'h1)[*6] |-> !derate_v_en_o)
      else $error("voltage derated outside warm zone");
endmodule

// >>> verification/bcseq_host_model.sv
`timescale 1ns/1ps
module bcseq_host_model (
   input  wire logic clock_i,
   input  wire logic int_oe_n_i,
   output logic      int_pin_o,
   output int        pulses_o,
   output int        width_o
);
   int cnt;
   // pull-up on the host side of the open-drain line
   assign int_pin_o = int_oe_n_i ? 1'b1 : 1'b0;
   always @(posedge clock_i)
   begin
      if (!int_pin_o)
         cnt <= cnt + 1;
      else if (cnt != 0)
      begin
         width_o <= cnt;
         pulses_o <= pulses_o + 1;
         cnt <= 0;
      end
   end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import bcseq_pkg::*;
;
   logic       clock, nrst, wr, rd, uv_ok, ov6, ov11, hdrm, above_pre;
   logic       below_rech, over104, cur_low, cv, die_hot, vloop, iloop, buv;
   logic       sw_en, pre_sel, di_en, di_half, dv_en, dv_200, sink, int_oe_n, int_pin;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, thr, rv;
   logic [2:0] zone;
   int         n_errors, cmp_count, seed, pulses, width, p0;

   bcseq_top #(.TERM_CYC(20), .SAFETY_CYC(1000), .PULSE_CYC(8)) uut (
      .clock_i(clock), .nrst_i(nrst), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .in_uv_ok_i(uv_ok), .in_ov_6v_i(ov6),
      .in_ov_11v_i(ov11), .input_battery_headroom_i(hdrm), .batt_above_pre_i(above_pre),
      .batt_below_rech_i(below_rech), .batt_over_104_i(over104), .batt_uv_i(buv),
      .cur_below_term_i(cur_low), .cv_loop_i(cv), .input_voltage_loop_active_i(vloop),
      .input_current_loop_active_i(iloop), .thermistor_zone_i(zone), .die_hot_i(die_hot),
      .switch_en_o(sw_en), .precharge_sel_o(pre_sel), .derate_i_en_o(di_en),
      .derate_i_half_o(di_half), .derate_v_en_o(dv_en), .derate_v_200_o(dv_200),
      .batt_sink_en_o(sink), .thresh_sel_o(thr), .int_oe_n_o(int_oe_n));

   bcseq_host_model host (.clock_i(clock), .int_oe_n_i(int_oe_n), .int_pin_o(int_pin),
      .pulses_o(pulses), .width_o(width));

   function automatic logic [7:0] st(input logic [1:0] ph);
      return {2'b00, ph, 4'h2};
   endfunction
   function automatic logic [7:0] flt(input logic [1:0] c);
      return {3'b000, c, 3'b000};
   endfunction

   task automatic final_report;
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      // read data still stands here, the edge's update lands after this
      @(posedge clock);
      chk("rdata", e, rdata);
   endtask

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   initial
   begin
      repeat (5000) @(posedge clock);
      n_errors++;
      final_report();
   end

   initial
   begin
      seed = 32'hf1d6;
      {nrst, wr, rd, uv_ok, ov6, ov11, hdrm, above_pre, below_rech} = 9'h000;
      {over104, cur_low, cv, die_hot, addr, wdata, zone} = 19'h00000;
      {vloop, iloop, buv} = 3'h0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      rc(BCSEQ_ADDR_INPUT, BCSEQ_RST_INPUT);
      rc(BCSEQ_ADDR_CURR, BCSEQ_RST_CURR);
      rc(BCSEQ_ADDR_VOLT, BCSEQ_RST_VOLT);
      rc(BCSEQ_ADDR_MISC, BCSEQ_RST_MISC);
      rc(BCSEQ_ADDR_TEMP, BCSEQ_RST_TEMP);
      rc(4'h3, 8'h00);
      uv_ok <= 1'b1;
      hdrm <= 1'b1;
      w(10);
      chk("switch", 8'h01, sw_en);
      chk("presel", 8'h01, pre_sel);
      rc(BCSEQ_ADDR_STATUS, st(BCSEQ_STAT_PRE));
      above_pre <= 1'b1;
      w(10);
      rc(BCSEQ_ADDR_STATUS, st(BCSEQ_STAT_FAST));
      chk("presel", 8'h00, pre_sel);
      // derating enabled, charge enabled
      wreg(BCSEQ_ADDR_VOLT, 8'h21);
      zone <= 3'h2;
      w(10);
      chk("derate_i", 8'h01, di_en);
      chk("derate_half", {7'h00, BCSEQ_RST_TEMP[BCSEQ_BIT_DISEL]}, di_half);
      zone <= 3'h1;
      w(10);
      chk("derate_v", 8'h01, dv_en);
      chk("derate_200", {7'h00, BCSEQ_RST_TEMP[BCSEQ_BIT_DVSEL]}, dv_200);
      zone <= 3'h4;
      w(10);
      chk("switch", 8'h00, sw_en);
      zone <= 3'h0;
      w(10);
      chk("switch", 8'h01, sw_en);
      w(20);
      p0 = pulses;
      cv <= 1'b1;
      cur_low <= 1'b1;
      vloop <= 1'b1;
      w(30);
      chk("irq_seen", 8'h01, {7'h00, pulses > p0});
      rc(BCSEQ_ADDR_STATUS, st(BCSEQ_STAT_FAST) | 8'h08);
      {vloop, iloop} <= 2'b01;
      w(30);
      rc(BCSEQ_ADDR_STATUS, st(BCSEQ_STAT_FAST) | 8'h04);
      iloop <= 1'b0;
      w(10);
      rc(BCSEQ_ADDR_STATUS, st(BCSEQ_STAT_FAST));
      w(20);
      rc(BCSEQ_ADDR_STATUS, st(BCSEQ_STAT_DONE));
      chk("switch", 8'h00, sw_en);
      cv <= 1'b0;
      cur_low <= 1'b0;
      below_rech <= 1'b1;
      w(10);
      rc(BCSEQ_ADDR_STATUS, st(BCSEQ_STAT_FAST));
      below_rech <= 1'b0;
      w(1100);
      rc(BCSEQ_ADDR_FAULT, flt(BCSEQ_FLT_TMR));
      chk("switch", 8'h00, sw_en);
      // unplug and reinsert the input to clear the timer fault
      uv_ok <= 1'b0;
      w(10);
      rc(BCSEQ_ADDR_FAULT, flt(BCSEQ_FLT_UV));
      uv_ok <= 1'b1;
      w(10);
      chk("switch", 8'h01, sw_en);
      {ov6, ov11} <= 2'b11;
      w(10);
      chk("switch", 8'h00, sw_en);
      rc(BCSEQ_ADDR_FAULT, flt(BCSEQ_FLT_OV));
      {ov6, ov11} <= 2'b00;
      die_hot <= 1'b1;
      w(10);
      chk("switch", 8'h00, sw_en);
      die_hot <= 1'b0;
      w(10);
      chk("switch", 8'h01, sw_en);
      over104 <= 1'b1;
      w(10);
      chk("switch", 8'h00, sw_en);
      chk("sink", 8'h01, sink);
      rc(BCSEQ_ADDR_MISC, BCSEQ_RST_MISC | 8'h20);
      over104 <= 1'b0;
      w(10);
      chk("sink", 8'h00, sink);
      wreg(BCSEQ_ADDR_VOLT, 8'hA1);
      over104 <= 1'b1;
      w(10);
      chk("sink", 8'h00, sink);
      rc(BCSEQ_ADDR_MISC, BCSEQ_RST_MISC);
      over104 <= 1'b0;
      // report-only thermistor mode
      wreg(BCSEQ_ADDR_MISC, 8'h00);
      w(20);
      p0 = pulses;
      zone <= 3'h4;
      w(20);
      chk("switch", 8'h01, sw_en);
      chk("irq_seen", 8'h01, {7'h00, pulses > p0});
      buv <= 1'b1;
      wreg(BCSEQ_ADDR_CURR, BCSEQ_RST_CURR & 8'hFB);
      w(10);
      rc(BCSEQ_ADDR_FAULT, 8'h80);
      buv <= 1'b0;
      zone <= 3'h0;
      wreg(BCSEQ_ADDR_CURR, 8'hFF);
      wreg(BCSEQ_ADDR_INPUT, 8'h80);
      rc(BCSEQ_ADDR_CURR, BCSEQ_RST_CURR);
      rc(BCSEQ_ADDR_INPUT, BCSEQ_RST_INPUT);
      repeat (8)
      begin
         rv = 8'($random(seed));
         wreg(BCSEQ_ADDR_TEMP, rv);
         rc(BCSEQ_ADDR_TEMP, rv);
         chk("thresh", {2'b00, rv[5:0]}, thr);
         chk("derate_half", {7'h00, rv[6]}, {7'h00, di_half});
      end
      // timer off: a charge longer than the timer span must not fault
      wreg(BCSEQ_ADDR_INPUT, BCSEQ_RST_INPUT & 8'hBF);
      w(1100);
      chk("switch", 8'h01, sw_en);
      chk("int_width", 8'h08, width[7:0]);
      final_report();
   end
endmodule

bind bcseq_top bcseq_asserts #(.PULSE_CYC(PULSE_CYC)) chk_u (
   .clock_i(clock_i), .nrst_i(nrst_i), .in_uv_ok_i(in_uv_ok_i), .in_ov_6v_i(in_ov_6v_i),
   .in_ov_11v_i(in_ov_11v_i), .batt_above_pre_i(batt_above_pre_i),
   .batt_over_104_i(batt_over_104_i), .thermistor_zone_i(thermistor_zone_i),
   .die_hot_i(die_hot_i), .switch_en_o(switch_en_o), .precharge_sel_o(precharge_sel_o),
   .derate_i_en_o(derate_i_en_o), .derate_v_en_o(derate_v_en_o),
   .batt_sink_en_o(batt_sink_en_o), .int_oe_n_o(int_oe_n_o));

// >>> verilog/bcseq_pkg.sv
package bcseq_pkg;

   // register offsets
   localparam logic [3:0] BCSEQ_ADDR_INPUT  = 4'h0;
   localparam logic [3:0] BCSEQ_ADDR_CURR   = 4'h1;
   localparam logic [3:0] BCSEQ_ADDR_VOLT   = 4'h2;
   localparam logic [3:0] BCSEQ_ADDR_STATUS = 4'h5;
   localparam logic [3:0] BCSEQ_ADDR_FAULT  = 4'h6;
   localparam logic [3:0] BCSEQ_ADDR_MISC   = 4'h7;
   localparam logic [3:0] BCSEQ_ADDR_TEMP   = 4'h8;

   // reset values
   localparam logic [7:0] BCSEQ_RST_INPUT = 8'h61;
   localparam logic [7:0] BCSEQ_RST_CURR  = 8'h2D;
   localparam logic [7:0] BCSEQ_RST_VOLT  = 8'h29;
   localparam logic [7:0] BCSEQ_RST_MISC  = 8'h10;
   localparam logic [7:0] BCSEQ_RST_TEMP  = 8'hEE;

   // field positions
   localparam int BCSEQ_BIT_REG_RESET   = 7;
   localparam int BCSEQ_BIT_TIMER_EN    = 6;
   localparam int BCSEQ_BIT_THERM_EN    = 2;
   localparam int BCSEQ_BIT_BOV_DIS     = 7;
   localparam int BCSEQ_BIT_DERATE_DIS  = 3;
   localparam int BCSEQ_BIT_CHARGE_ENABLE_BIT      = 0;
   localparam int BCSEQ_BIT_SUSPEND     = 4;
   localparam int BCSEQ_BIT_OV_SEL      = 3;
   localparam int BCSEQ_BIT_DVSEL       = 7;
   localparam int BCSEQ_BIT_DISEL       = 6;

   // status and fault codes
   localparam logic [1:0] BCSEQ_STAT_IDLE = 2'h0;
   localparam logic [1:0] BCSEQ_STAT_PRE  = 2'h1;
   localparam logic [1:0] BCSEQ_STAT_FAST = 2'h2;
   localparam logic [1:0] BCSEQ_STAT_DONE = 2'h3;
   localparam logic [1:0] BCSEQ_FLT_NONE  = 2'h0;
   localparam logic [1:0] BCSEQ_FLT_UV    = 2'h1;
   localparam logic [1:0] BCSEQ_FLT_OV    = 2'h2;
   localparam logic [1:0] BCSEQ_FLT_TMR   = 2'h3;
   localparam logic [2:0] BCSEQ_ZONE_NORMAL = 3'h0;

   // timing
   localparam int BCSEQ_CLK_MHZ      = 250;
   localparam int BCSEQ_TERM_MS      = 20;
   localparam int BCSEQ_PULSE_US     = 50;
   localparam int BCSEQ_TERM_CYC     = BCSEQ_TERM_MS * 1000 * BCSEQ_CLK_MHZ;
   localparam int BCSEQ_PULSE_CYC    = BCSEQ_PULSE_US * BCSEQ_CLK_MHZ;
   localparam longint BCSEQ_SAFETY_HOURS = 20;
   localparam longint BCSEQ_SAFETY_CYC =
      BCSEQ_SAFETY_HOURS * 64'd3600 * 64'd1000000 * BCSEQ_CLK_MHZ;

endpackage

// >>> verilog/bcseq_pulse.sv
`timescale 1ns/1ps
module bcseq_pulse
   import bcseq_pkg::*;
#(
   parameter int LEN = 12500
)(
   input  wire logic clock_i,
   input  wire logic nrst_i,
   input  wire logic ce_i,
   input  wire logic event_i,
   output logic      irq_oe_n_o
);

   typedef struct packed
   {
      logic        busy;
      logic        pend;
      logic [15:0] cnt;
      logic        oe_n;
   } bcseq_pulse_s;

   bcseq_pulse_s st_reg;
   bcseq_pulse_s st_next;

   always_comb
   begin
      st_next = st_reg;
      if (st_reg.busy)
      begin
         // events during a pulse queue one more, never stretch it
         if (event_i)
            st_next.pend = 1'b1;
         if (st_reg.cnt == 16'(LEN - 1))
         begin
            st_next.busy = 1'b0;
            st_next.cnt  = '0;
         end
         else
            st_next.cnt = st_reg.cnt + 16'h0001;
      end
      else if (event_i || st_reg.pend)
      begin
         st_next.busy = 1'b1;
         st_next.pend = 1'b0;
      end
      st_next.oe_n = ~st_next.busy;
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         st_reg <= '{busy: 1'b0, pend: 1'b0, cnt: 16'h0000, oe_n: 1'b1};
      else if (ce_i)
         st_reg <= st_next;
   end

   assign irq_oe_n_o = st_reg.oe_n;

endmodule

// >>> verilog/bcseq_sync.sv
`timescale 1ns/1ps
module bcseq_sync
   import bcseq_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         clock_i,
   input  wire logic         nrst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   typedef struct packed
   {
      logic [W-1:0] meta;
      logic [W-1:0] out;
   } bcseq_sync_s;

   bcseq_sync_s st_reg;
   bcseq_sync_s st_next;

   always_comb
   begin
      st_next      = st_reg;
      st_next.meta = async_i;
      st_next.out  = st_reg.meta;
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         st_reg <= '0;
      else if (ce_i)
         st_reg <= st_next;
   end

   assign sync_o = st_reg.out;

endmodule

// >>> verilog/bcseq_top.sv
// Contract
// [R1] supply good resets all registers to defaults
// [R2] start needs input, temp, timer, enable, battery ok
// [R3] host restarts via replug or enable toggle
// [R4] below 3V precharge status 01, else 10
// [R5] default precharge 150mA, fast 1A
// [R6] current may drop under input loops
// [R7] terminate after 20ms low current in CV
// [R8] termination sets status 11, pulses interrupt
// [R9] recharge below target minus 200mV
// [R10] safety timer resets per cycle, disableable
// [R11] timer expiry stops, fault 11, until replug
// [R12] pulse on entering input loops
// [R13] thermistor disabled means ignored
// [R14] suspend switching outside hot-cold window
// [R15] report-only mode pulses on zone change
// [R16] cool zone derates current
// [R17] warm zone lowers voltage target
// [R18] two hot/cold, four warm/cool thresholds
// [R19] 50us low interrupt on events
// [R20] battery overvoltage stops, flags, sinks
// [R21] overvoltage disable suppresses protection
// [R22] input overvoltage 6V/11V shuts converter
// [R23] thermal shutdown 150C, resume 120C
// [R24] status codes 00/01/10/11
// [R25] fault codes 00/01/10/11
// [R26] derate current 14.3% or 50%
// [R27] register reset bit self-clears
// [R28] merged events give single pulses
// [R29] analog flags synchronised before use
`timescale 1ns/1ps
module bcseq_top
   import bcseq_pkg::*;
#(
   parameter int     TERM_CYC   = BCSEQ_TERM_CYC,
   parameter longint SAFETY_CYC = BCSEQ_SAFETY_CYC,
   parameter int     PULSE_CYC  = BCSEQ_PULSE_CYC
)(
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   input  wire logic       ce_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       in_uv_ok_i,
   input  wire logic       in_ov_6v_i,
   input  wire logic       in_ov_11v_i,
   input  wire logic       input_battery_headroom_i,
   input  wire logic       batt_above_pre_i,
   input  wire logic       batt_below_rech_i,
   input  wire logic       batt_over_104_i,
   input  wire logic       batt_uv_i,
   input  wire logic       cur_below_term_i,
   input  wire logic       cv_loop_i,
   input  wire logic       input_voltage_loop_active_i,
   input  wire logic       input_current_loop_active_i,
   input  wire logic [2:0] thermistor_zone_i,
   input  wire logic       die_hot_i,
   output logic            switch_en_o,
   output logic            precharge_sel_o,
   output logic            derate_i_en_o,
   output logic            derate_i_half_o,
   output logic            derate_v_en_o,
   output logic            derate_v_200_o,
   output logic            batt_sink_en_o,
   output logic [7:0]      thresh_sel_o,
   output logic            int_oe_n_o
);

   typedef enum logic [1:0]
   {
      BCSEQ_IDLE,
      BCSEQ_CHARGE,
      BCSEQ_DONE,
      BCSEQ_FAULT
   } bcseq_state_e;

   typedef struct packed
   {
      logic [7:0]   r_input;
      logic [7:0]   r_curr;
      logic [7:0]   r_volt;
      logic [7:0]   r_misc;
      logic [7:0]   r_temp;
      bcseq_state_e state;
      logic [31:0]  term_cnt;
      logic [47:0]  safe_cnt;
      logic         tmr_flt;
      logic         bov;
      logic         prev_en;
      logic         prev_ten;
      logic         prev_good;
      logic [7:0]   prev_stat;
      logic [7:0]   prev_flt;
      logic         event_p;
      logic [7:0]   rdata;
      logic         sw_en;
      logic         pre_sel;
      logic         di_en;
      logic         di_half;
      logic         dv_en;
      logic         dv_200;
      logic         sink;
   } bcseq_s;

   bcseq_s st_reg;
   bcseq_s st_next;

   logic [13:0] flags_s;
   logic [2:0]  zone_s;

   bcseq_sync #(.W(17)) u_sync
   (
      .clock_i (clock_i),
      .nrst_i  (nrst_i),
      .ce_i    (ce_i),
      .async_i ({in_uv_ok_i, in_ov_6v_i, in_ov_11v_i, input_battery_headroom_i,
                 batt_above_pre_i, batt_below_rech_i, batt_over_104_i, batt_uv_i,
                 cur_below_term_i, cv_loop_i, input_voltage_loop_active_i,
                 input_current_loop_active_i, die_hot_i, 1'b0, thermistor_zone_i}),
      .sync_o  ({flags_s, zone_s})                                  // [R29]
   );

   logic       uv_ok;
   logic       ov6;
   logic       ov11;
   logic       hdrm;
   logic       above_pre;
   logic       below_rech;
   logic       over104;
   logic       buv;
   logic       below_term;
   logic       cv;
   logic       vloop;
   logic       iloop;
   logic       hot;
   logic       unused_s;
   assign {uv_ok, ov6, ov11, hdrm, above_pre, below_rech, over104, buv,
           below_term, cv, vloop, iloop, hot, unused_s} = flags_s;

   logic       in_ov;
   logic       input_good;
   logic       therm_en;
   logic       zone_bad;
   logic       zone_cool;
   logic       zone_warm;
   logic       bov_active;
   logic       start_ok;
   logic       run_ok;
   logic       derate_on;
   logic [1:0] stat_code;
   logic [1:0] flt_code;
   logic [2:0] zone_rep;
   logic [7:0] stat_reg_v;
   logic [7:0] flt_reg_v;

   always_comb
   begin
      in_ov      = st_reg.r_misc[BCSEQ_BIT_OV_SEL] ? ov11 : ov6;          // [R22]
      input_good = uv_ok && !in_ov && hdrm;
      therm_en   = st_reg.r_curr[BCSEQ_BIT_THERM_EN];
      zone_rep   = therm_en ? zone_s : BCSEQ_ZONE_NORMAL;                 // [R13]
      zone_bad   = zone_rep == 3'h3 || zone_rep == 3'h4;
      zone_cool  = zone_rep == 3'h2;
      zone_warm  = zone_rep == 3'h1;
      derate_on  = !st_reg.r_volt[BCSEQ_BIT_DERATE_DIS];
      bov_active = over104 && !st_reg.r_volt[BCSEQ_BIT_BOV_DIS];          // [R21]
      start_ok   = input_good && !st_reg.tmr_flt && !st_reg.bov           // [R2]
                   && st_reg.r_volt[BCSEQ_BIT_CHARGE_ENABLE_BIT]
                   && !(st_reg.r_misc[BCSEQ_BIT_SUSPEND] && zone_bad);
      run_ok     = start_ok && !hot;                                      // [R23]
      unique case (st_reg.state)                                          // [R24]
         BCSEQ_CHARGE: stat_code = above_pre ? BCSEQ_STAT_FAST : BCSEQ_STAT_PRE; // [R4]
         BCSEQ_DONE:   stat_code = BCSEQ_STAT_DONE;
         default:      stat_code = BCSEQ_STAT_IDLE;
      endcase
      if (st_reg.tmr_flt)                                                 // [R25]
         flt_code = BCSEQ_FLT_TMR;
      else if (in_ov)
         flt_code = BCSEQ_FLT_OV;
      else if (!uv_ok)
         flt_code = BCSEQ_FLT_UV;
      else
         flt_code = BCSEQ_FLT_NONE;
      stat_reg_v = {2'b00, stat_code, vloop, iloop, input_good, 1'b0};
      flt_reg_v  = {buv, 2'b00, flt_code, zone_rep};
   end

   always_comb
   begin
      st_next         = st_reg;
      st_next.event_p = 1'b0;
      st_next.prev_en   = st_reg.r_volt[BCSEQ_BIT_CHARGE_ENABLE_BIT];
      st_next.prev_ten  = st_reg.r_input[BCSEQ_BIT_TIMER_EN];
      st_next.prev_good = input_good;
      st_next.prev_stat = stat_reg_v;
      st_next.prev_flt  = flt_reg_v;

      // battery overvoltage latch clears when voltage is normal or BCSEQ_BIT_BOV_DIS is set
      if (bov_active)
         st_next.bov = 1'b1;                                              // [R20]
      else if (!over104 || st_reg.r_volt[BCSEQ_BIT_BOV_DIS])
         st_next.bov = 1'b0;

      // timer fault held until input removal
      if (!input_good && !uv_ok)
         st_next.tmr_flt = 1'b0;                                          // [R11]

      // safety timer
      if (st_reg.r_input[BCSEQ_BIT_TIMER_EN] && !st_reg.prev_ten)
         st_next.safe_cnt = '0;                                           // [R10]
      else if (st_reg.state == BCSEQ_CHARGE && st_reg.r_input[BCSEQ_BIT_TIMER_EN])
         st_next.safe_cnt = st_reg.safe_cnt + 48'h1;

      if (below_term && cv && !vloop && !iloop && st_reg.state == BCSEQ_CHARGE)
         st_next.term_cnt = st_reg.term_cnt + 32'h1;                      // [R7]
      else
         st_next.term_cnt = '0;

      unique case (st_reg.state)
         BCSEQ_IDLE:
            if (start_ok && !(st_reg.prev_en && 1'b0))
            begin
               st_next.state    = BCSEQ_CHARGE;
               st_next.safe_cnt = '0;                                     // [R10]
            end
         BCSEQ_CHARGE:
            if (!start_ok)
               st_next.state = BCSEQ_IDLE;                                // [R20]
            else if (st_reg.r_input[BCSEQ_BIT_TIMER_EN] &&
                     st_reg.safe_cnt >= 48'(SAFETY_CYC - 1))
            begin
               st_next.state   = BCSEQ_FAULT;                             // [R11]
               st_next.tmr_flt = 1'b1;
            end
            else if (st_reg.term_cnt >= 32'(TERM_CYC - 1))
               st_next.state = BCSEQ_DONE;                                // [R8]
         BCSEQ_DONE:
            // new cycle only by replug, enable toggle or recharge
            if (!input_good || !st_reg.r_volt[BCSEQ_BIT_CHARGE_ENABLE_BIT])
               st_next.state = BCSEQ_IDLE;                                // [R3]
            else if (below_rech && start_ok)
            begin
               st_next.state    = BCSEQ_CHARGE;                           // [R9]
               st_next.safe_cnt = '0;
            end
         BCSEQ_FAULT:
            if (!st_reg.tmr_flt)
               st_next.state = BCSEQ_IDLE;
      endcase

      // one merged event stream feeds the pulse shaper
      if ((input_good && !st_reg.prev_good)                               // [R19]
          || stat_reg_v != st_reg.prev_stat                               // [R8] [R12]
          || flt_reg_v != st_reg.prev_flt                                 // [R11] [R15]
          || (bov_active && !st_reg.bov))                                 // [R20]
         st_next.event_p = 1'b1;                                          // [R28]

      // outputs
      st_next.sw_en   = st_reg.state == BCSEQ_CHARGE && run_ok;           // [R14]
      st_next.pre_sel = !above_pre;                                       // [R4] [R5]
      st_next.di_en   = derate_on && zone_cool;                           // [R16] [R6]
      st_next.di_half = st_reg.r_temp[BCSEQ_BIT_DISEL];                   // [R26]
      st_next.dv_en   = derate_on && zone_warm;                           // [R17]
      st_next.dv_200  = st_reg.r_temp[BCSEQ_BIT_DVSEL];
      st_next.sink    = bov_active;                                       // [R20]

      // register port
      st_next.rdata = 8'h00;
      if (rd_i)
      begin
         unique case (addr_i)
            BCSEQ_ADDR_INPUT:  st_next.rdata = st_reg.r_input;
            BCSEQ_ADDR_CURR:   st_next.rdata = st_reg.r_curr;
            BCSEQ_ADDR_VOLT:   st_next.rdata = st_reg.r_volt;
            BCSEQ_ADDR_STATUS: st_next.rdata = stat_reg_v;
            BCSEQ_ADDR_FAULT:  st_next.rdata = flt_reg_v;
            BCSEQ_ADDR_MISC:   st_next.rdata = {2'b00, st_reg.bov, st_reg.r_misc[4:2], 2'b00};
            BCSEQ_ADDR_TEMP:   st_next.rdata = st_reg.r_temp;
            default:           st_next.rdata = 8'h00;
         endcase
      end
      if (wr_i)
      begin
         unique case (addr_i)
            BCSEQ_ADDR_INPUT:
               if (wdata_i[BCSEQ_BIT_REG_RESET])
               begin
                  st_next.r_input = BCSEQ_RST_INPUT;                      // [R27]
                  st_next.r_curr  = BCSEQ_RST_CURR;
                  st_next.r_volt  = BCSEQ_RST_VOLT;
                  st_next.r_misc  = BCSEQ_RST_MISC;
                  st_next.r_temp  = BCSEQ_RST_TEMP;
               end
               else
                  st_next.r_input = {1'b0, wdata_i[6:0]};
            BCSEQ_ADDR_CURR:   st_next.r_curr = wdata_i;
            BCSEQ_ADDR_VOLT:   st_next.r_volt = wdata_i;
            BCSEQ_ADDR_MISC:   st_next.r_misc = {3'b000, wdata_i[4:2], 2'b00};
            BCSEQ_ADDR_TEMP:   st_next.r_temp = wdata_i;                  // [R18]
            default:           ;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_reg         <= '0;                                            // [R1]
         st_reg.r_input <= BCSEQ_RST_INPUT;
         st_reg.r_curr  <= BCSEQ_RST_CURR;
         st_reg.r_volt  <= BCSEQ_RST_VOLT;
         st_reg.r_misc  <= BCSEQ_RST_MISC;
         st_reg.r_temp  <= BCSEQ_RST_TEMP;
         st_reg.state   <= BCSEQ_IDLE;
         st_reg.pre_sel <= 1'b1;
         // no input yet reads as undervoltage; match it so reset raises no pulse
         st_reg.prev_flt <= {3'b000, BCSEQ_FLT_UV, 3'b000};
      end
      else if (ce_i)
         st_reg <= st_next;
   end

   bcseq_pulse #(.LEN(PULSE_CYC)) u_pulse
   (
      .clock_i    (clock_i),
      .nrst_i     (nrst_i),
      .ce_i       (ce_i),
      .event_i    (st_reg.event_p),
      .irq_oe_n_o (int_oe_n_o)                                            // [R19]
   );

   assign rdata_o         = st_reg.rdata;
   assign switch_en_o     = st_reg.sw_en;
   assign precharge_sel_o = st_reg.pre_sel;
   assign derate_i_en_o   = st_reg.di_en;
   assign derate_i_half_o = st_reg.di_half;
   assign derate_v_en_o   = st_reg.dv_en;
   assign derate_v_200_o  = st_reg.dv_200;
   assign batt_sink_en_o  = st_reg.sink;
   assign thresh_sel_o    = {2'b00, st_reg.r_temp[5:0]};

endmodule
